// ---- rtl/apcrb_top.sv ----
// How it works
// - Alignment enable bit 11, reset one, lets the alignment pin hold the converter.
// - Conversions restart on pin release so shared-pin devices start together.
// - Fault mode 01 ORs the fault pin with internal errors into the fault flag.
// - Fault mode 10 drives the pin open-drain low; 00 disables it; 11 reserved.
// - Pin config at 0x6 resets to 0x0800; reserved bits read zero.
// - Identity at 0x7 is read-only and returns a fixed 16-bit code.
// - Lowest identity digit is the silicon revision; hosts compare upper digits.
// - Channel 0 offset at 0x8, 24 bits, resets 0x800000, applied to conversions.
// - Offsets for channels 1 to 3 at 0x9 to 0xb, reset 0x800000.
// - Channel 0 gain at 0xc resets to its factory trim and is applied.
// - Gains for channels 1 to 3 at 0xd to 0xf reset to trim.
`timescale 1ns/1ps
`include "apcrb_regs.svh"

module apcrb_top
  import apcrb_pkg::*;
#(
  parameter logic [11:0] PART_CODE   = 12'h5a3,      // Arbitrary value.
  parameter logic [3:0]  SILICON_REV = 4'h1,         // Arbitrary value.
  parameter apcrb_word_t GAIN_TRIM0  = `APCRB_GAIN_RST,
  parameter apcrb_word_t GAIN_TRIM1  = `APCRB_GAIN_RST,
  parameter apcrb_word_t GAIN_TRIM2  = `APCRB_GAIN_RST,
  parameter apcrb_word_t GAIN_TRIM3  = `APCRB_GAIN_RST
)(
  input  wire logic        clock,         // System clock, 50 MHz.
  input  wire logic        arst_n,        // Asynchronous reset, active low.
  input  wire logic [7:0]  reg_addr,      // Register address.
  input  wire logic [23:0] reg_wdata,     // Register write data.
  input  wire logic        reg_wr,        // Write strobe.
  input  wire logic        reg_rd,        // Read strobe.
  output logic      [23:0] reg_rdata,     // Read data, cycle after the read strobe.
  input  wire logic        sync_n_pin,    // Conversion alignment pin, active low.
  input  wire logic        fault_pin_i,   // Fault pad level, low flags a fault.
  output logic             fault_pin_o,   // Fault pin drive value.
  output logic             fault_pin_oe,  // Fault pin output enable.
  input  wire logic        adc_err_int,   // Internal converter error, same clock.
  input  wire logic [1:0]  conv_chan,     // Channel whose calibration is wanted.
  output apcrb_word_t      conv_offset,   // Offset for that channel.
  output apcrb_word_t      conv_gain,     // Gain for that channel.
  output logic             conv_hold,     // Holds converter and filter in reset.
  output logic             conv_start,    // One-cycle pulse when conversions start.
  output logic             adc_fault,     // Converter fault flag.
  output logic             irq            // Interrupt, active high level.
);

  localparam logic [15:0] PART_ID = {PART_CODE, SILICON_REV};

  apcrb_cal_if cal ();

  logic [15:0]             pin_cfg_r;
  logic                    sync_s1_r;
  logic                    sync_s2_r;
  logic                    fault_s1_r;
  logic                    fault_s2_r;
  apcrb_conv_state_e       cv_state_r;
  apcrb_conv_state_e       cv_state_nxt;
  logic                    conv_start_r;
  logic                    adc_fault_r;
  logic                    adc_fault_nxt;
  logic                    fault_drive_r;
  logic [`APCRB_IRQ_W-1:0] irq_status_r;
  logic [`APCRB_IRQ_W-1:0] irq_mask_r;
  logic [`APCRB_IRQ_W-1:0] irq_event;
  logic [23:0]             rdata_local_r;
  logic                    rd_mem_r;
  logic                    sync_en;
  apcrb_fault_mode_e       fault_mode;
  logic                    cal_sel;

  assign sync_en    = pin_cfg_r[`APCRB_SYNC_EN_BIT];
  assign fault_mode = apcrb_fault_mode_e'(pin_cfg_r[`APCRB_FMODE_MSB:`APCRB_FMODE_LSB]);
  assign cal_sel    = (reg_addr[7:3] == 5'h01);

  // --------------------------------------------------------------------------
  // Pin configuration register
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      pin_cfg_r <= `APCRB_PIN_CFG_RST;
    else if (reg_wr && (reg_addr == `APCRB_ADDR_PIN_CFG))
      pin_cfg_r <= reg_wdata[15:0] & `APCRB_PIN_CFG_WMASK;
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_s1_r  <= 1'b1;
      sync_s2_r  <= 1'b1;
      fault_s1_r <= 1'b1;
      fault_s2_r <= 1'b1;
    end
    else
    begin
      sync_s1_r  <= sync_n_pin;
      sync_s2_r  <= sync_s1_r;
      fault_s1_r <= fault_pin_i;
      fault_s2_r <= fault_s1_r;
    end
  end

  // --------------------------------------------------------------------------
  // Conversion hold and start
  // --------------------------------------------------------------------------
  always_comb
  begin
    cv_state_nxt = cv_state_r;
    case (cv_state_r)
      CV_RUN:
        if (sync_en && !sync_s2_r)
          cv_state_nxt = CV_HOLD;
      CV_HOLD:
        if (!sync_en || sync_s2_r)
          cv_state_nxt = CV_RUN;
      default:
        cv_state_nxt = CV_RUN;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      cv_state_r <= CV_RUN;
    else
      cv_state_r <= cv_state_nxt;
  end

  // A start pulse marks the release so every device on a shared pin restarts on the same edge.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      conv_start_r <= 1'b0;
    else
      conv_start_r <= (cv_state_r == CV_HOLD) && (cv_state_nxt == CV_RUN);
  end

  assign conv_hold  = (cv_state_r == CV_HOLD);
  assign conv_start = conv_start_r;

  // --------------------------------------------------------------------------
  // Fault pin modes
  // --------------------------------------------------------------------------
  // The shared pad idles high through its pull-up, so a low level is a fault.
  always_comb
  begin
    case (fault_mode)
      FM_IN:
        adc_fault_nxt = adc_err_int || !fault_s2_r;
      default:
        adc_fault_nxt = adc_err_int;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      adc_fault_r <= 1'b0;
    else
      adc_fault_r <= adc_fault_nxt;
  end

  // The reserved mode is treated as disabled so the pin never floats into a drive.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      fault_drive_r <= 1'b0;
    else
      fault_drive_r <= (fault_mode == FM_OUT) && adc_err_int;
  end

  assign adc_fault    = adc_fault_r;
  assign fault_pin_o  = 1'b0;
  assign fault_pin_oe = fault_drive_r;

  // --------------------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------------------
  always_comb
  begin
    irq_event                       = '0;
    irq_event[`APCRB_IRQ_FAULT_BIT] = adc_fault_nxt && !adc_fault_r;
    irq_event[`APCRB_IRQ_START_BIT] = (cv_state_r == CV_HOLD) && (cv_state_nxt == CV_RUN);
  end

  // A new event in the cycle of its clear keeps the bit set.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      irq_status_r <= '0;
    else if (reg_wr && (reg_addr == `APCRB_ADDR_IRQ_STATUS))
      irq_status_r <= (irq_status_r & ~reg_wdata[`APCRB_IRQ_W-1:0]) | irq_event;
    else
      irq_status_r <= irq_status_r | irq_event;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      irq_mask_r <= '0;
    else if (reg_wr && (reg_addr == `APCRB_ADDR_IRQ_MASK))
      irq_mask_r <= reg_wdata[`APCRB_IRQ_W-1:0];
  end

  assign irq = |(irq_status_r & irq_mask_r);

  // --------------------------------------------------------------------------
  // Calibration store
  // --------------------------------------------------------------------------
  assign cal.wr_en   = reg_wr && cal_sel;
  assign cal.wr_idx  = reg_addr[2:0];
  assign cal.wr_data = reg_wdata;
  assign cal.rd_en   = reg_rd && cal_sel;
  assign cal.rd_idx  = reg_addr[2:0];
  assign cal.ch_sel  = conv_chan;

  apcrb_cal_mem #(
    .GAIN_TRIM0 (GAIN_TRIM0),
    .GAIN_TRIM1 (GAIN_TRIM1),
    .GAIN_TRIM2 (GAIN_TRIM2),
    .GAIN_TRIM3 (GAIN_TRIM3)
  ) u_cal_mem (
    .clock  (clock),
    .arst_n (arst_n),
    .cal    (cal)
  );

  assign conv_offset = cal.ch_offset;
  assign conv_gain   = cal.ch_gain;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rd_mem_r <= 1'b0;
    else
      rd_mem_r <= reg_rd && cal_sel;
  end

  // The identity register has no write path at all, so a write there is dropped.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rdata_local_r <= 24'h000000;
    else if (!reg_rd)
      rdata_local_r <= 24'h000000;
    else if (reg_addr == `APCRB_ADDR_PIN_CFG)
      rdata_local_r <= {8'h00, pin_cfg_r};
    else if (reg_addr == `APCRB_ADDR_PART_ID)
      rdata_local_r <= {8'h00, PART_ID};
    else if (reg_addr == `APCRB_ADDR_IRQ_STATUS)
      rdata_local_r <= {22'h000000, irq_status_r};
    else if (reg_addr == `APCRB_ADDR_IRQ_MASK)
      rdata_local_r <= {22'h000000, irq_mask_r};
    else if (reg_addr == `APCRB_ADDR_CONV_STATUS)
      rdata_local_r <= {22'h000000, conv_hold, adc_fault_r};
    else
      rdata_local_r <= 24'h000000;
  end

  assign reg_rdata = rd_mem_r ? cal.rd_q : rdata_local_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_hold_when_low;
    @(posedge clock) disable iff (!arst_n)
    (sync_en && !sync_s2_r) |=> conv_hold;
  endproperty
  a_hold_when_low: assert property (p_hold_when_low) else $error("Converter not held by alignment pin.");

  property p_no_hold_disabled;
    @(posedge clock) disable iff (!arst_n)
    !sync_en |=> !conv_hold;
  endproperty
  a_no_hold_disabled: assert property (p_no_hold_disabled) else $error("Hold while alignment pin disabled.");

  sequence s_release;
    conv_hold ##1 !conv_hold;
  endsequence

  property p_start_on_release;
    @(posedge clock) disable iff (!arst_n)
    s_release |-> (conv_start ##1 !conv_start);
  endproperty
  a_start_on_release: assert property (p_start_on_release) else $error("No single start pulse on release.");

  property p_start_only_release;
    @(posedge clock) disable iff (!arst_n)
    conv_start |-> ($past(conv_hold) && !conv_hold);
  endproperty
  a_start_only_release: assert property (p_start_only_release) else $error("Start pulse without release.");

  property p_fault_merge;
    @(posedge clock) disable iff (!arst_n)
    ((fault_mode == FM_IN) && !fault_s2_r) |=> adc_fault;
  endproperty
  a_fault_merge: assert property (p_fault_merge) else $error("Fault pin not merged into fault flag.");

  property p_fault_drive;
    @(posedge clock) disable iff (!arst_n)
    ((fault_mode == FM_OUT) && adc_err_int) |=> (fault_pin_oe && !fault_pin_o);
  endproperty
  a_fault_drive: assert property (p_fault_drive) else $error("Fault pin not driven low.");

  property p_fault_quiet;
    @(posedge clock) disable iff (!arst_n)
    (fault_mode != FM_OUT) |=> !fault_pin_oe;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("Fault pin driven outside output mode.");

  property p_cfg_reserved;
    @(posedge clock) disable iff (!arst_n)
    (reg_rd && (reg_addr == `APCRB_ADDR_PIN_CFG)) |=> ((reg_rdata & ~{8'h00, `APCRB_PIN_CFG_WMASK}) == 24'h000000);
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved) else $error("Reserved configuration bits not zero.");

  sequence s_id_write_read;
    (reg_wr && (reg_addr == `APCRB_ADDR_PART_ID)) ##1 (reg_rd && (reg_addr == `APCRB_ADDR_PART_ID));
  endsequence

  property p_id_fixed;
    @(posedge clock) disable iff (!arst_n)
    s_id_write_read |=> (reg_rdata == {8'h00, PART_ID});
  endproperty
  a_id_fixed: assert property (p_id_fixed) else $error("Identity changed by a write.");

  property p_id_read;
    @(posedge clock) disable iff (!arst_n)
    (reg_rd && (reg_addr == `APCRB_ADDR_PART_ID)) |=> (reg_rdata[15:4] == PART_CODE);
  endproperty
  a_id_read: assert property (p_id_read) else $error("Identity part code read wrong.");

  property p_cfg_write;
    @(posedge clock) disable iff (!arst_n)
    (reg_wr && (reg_addr == `APCRB_ADDR_PIN_CFG))
    |=> (pin_cfg_r == ($past(reg_wdata[15:0]) & `APCRB_PIN_CFG_WMASK));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("Configuration write not stored as masked.");

  property p_start_flag;
    @(posedge clock) disable iff (!arst_n)
    conv_start |-> irq_status_r[`APCRB_IRQ_START_BIT];
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("Start pulse not flagged in status.");

endmodule

// ---- rtl/apcrb_regs.svh ----
`ifndef APCRB_REGS_SVH
`define APCRB_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define APCRB_ADDR_PIN_CFG     8'h06
`define APCRB_ADDR_PART_ID     8'h07
`define APCRB_ADDR_OFS0        8'h08
`define APCRB_ADDR_OFS1        8'h09
`define APCRB_ADDR_OFS2        8'h0a
`define APCRB_ADDR_OFS3        8'h0b
`define APCRB_ADDR_CHANNEL_ZERO_GAIN_VALUE       8'h0c
`define APCRB_ADDR_CHANNEL_ONE_GAIN_VALUE       8'h0d
`define APCRB_ADDR_CHANNEL_TWO_GAIN_VALUE       8'h0e
`define APCRB_ADDR_CHANNEL_THREE_GAIN_VALUE       8'h0f
`define APCRB_ADDR_IRQ_STATUS  8'h10
`define APCRB_ADDR_IRQ_MASK    8'h11
`define APCRB_ADDR_CONV_STATUS 8'h12

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define APCRB_PIN_CFG_RST      16'h0800
`define APCRB_PIN_CFG_WMASK    16'h0e00
`define APCRB_SYNC_EN_BIT      11
`define APCRB_FMODE_MSB        10
`define APCRB_FMODE_LSB        9
`define APCRB_OFS_RST          24'h800000
`define APCRB_GAIN_RST         24'h500000
`define APCRB_IRQ_FAULT_BIT    0
`define APCRB_IRQ_START_BIT    1
`define APCRB_IRQ_W            2
`define APCRB_CONV_FAULT_BIT   0
`define APCRB_CONV_HOLD_BIT    1

`endif

// ---- rtl/apcrb_pkg.sv ----
package apcrb_pkg;

  typedef enum logic [1:0] {
    FM_OFF,
    FM_IN,
    FM_OUT,
    FM_RSVD
  } apcrb_fault_mode_e;

  typedef enum logic {
    CV_RUN,
    CV_HOLD
  } apcrb_conv_state_e;

  typedef logic [23:0] apcrb_word_t;
  typedef logic [2:0]  apcrb_cal_idx_t;

endpackage

// ---- rtl/apcrb_cal_if.sv ----
`timescale 1ns/1ps

interface apcrb_cal_if;
  import apcrb_pkg::*;

  logic           wr_en;
  apcrb_cal_idx_t wr_idx;
  apcrb_word_t    wr_data;
  logic           rd_en;
  apcrb_cal_idx_t rd_idx;
  apcrb_word_t    rd_q;
  logic [1:0]     ch_sel;
  apcrb_word_t    ch_offset;
  apcrb_word_t    ch_gain;

  modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_idx, ch_sel,
                input  rd_q, ch_offset, ch_gain);
  modport mem  (input  wr_en, wr_idx, wr_data, rd_en, rd_idx, ch_sel,
                output rd_q, ch_offset, ch_gain);
endinterface

// ---- rtl/apcrb_cal_mem.sv ----
`timescale 1ns/1ps
`include "apcrb_regs.svh"

module apcrb_cal_mem
  import apcrb_pkg::*;
#(
  parameter apcrb_word_t GAIN_TRIM0 = `APCRB_GAIN_RST,
  parameter apcrb_word_t GAIN_TRIM1 = `APCRB_GAIN_RST,
  parameter apcrb_word_t GAIN_TRIM2 = `APCRB_GAIN_RST,
  parameter apcrb_word_t GAIN_TRIM3 = `APCRB_GAIN_RST
)(
  input wire logic    clock,   // System clock.
  input wire logic    arst_n,  // Asynchronous reset, active low.
  apcrb_cal_if.mem    cal      // Calibration access from the register bank.
);

  localparam apcrb_word_t GAIN_TRIM [4] = '{GAIN_TRIM0, GAIN_TRIM1, GAIN_TRIM2, GAIN_TRIM3};

  apcrb_word_t mem_r [8];
  apcrb_word_t rd_q_r;
  apcrb_word_t ch_offset_r;
  apcrb_word_t ch_gain_r;

  // --------------------------------------------------------------------------
  // Storage: entries 0 to 3 hold offsets, 4 to 7 hold gains.
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < 8; i++)
  begin : g_entry
    always_ff @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
        mem_r[i] <= (i < 4) ? `APCRB_OFS_RST : GAIN_TRIM[i % 4];
      else if (cal.wr_en && (cal.wr_idx == 3'(i)))
        mem_r[i] <= cal.wr_data;
    end
  end

  // --------------------------------------------------------------------------
  // Registered read ports for software and for the conversion path.
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rd_q_r <= 24'h000000;
    else if (cal.rd_en)
      rd_q_r <= mem_r[cal.rd_idx];
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ch_offset_r <= `APCRB_OFS_RST;
      ch_gain_r   <= GAIN_TRIM0;
    end
    else
    begin
      ch_offset_r <= mem_r[{1'b0, cal.ch_sel}];
      ch_gain_r   <= mem_r[{1'b1, cal.ch_sel}];
    end
  end

  assign cal.rd_q      = rd_q_r;
  assign cal.ch_offset = ch_offset_r;
  assign cal.ch_gain   = ch_gain_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_wr_then_rd;
    cal.wr_en ##1 (cal.rd_en && !cal.wr_en && (cal.rd_idx == $past(cal.wr_idx)));
  endsequence

  property p_cal_readback;
    @(posedge clock) disable iff (!arst_n)
    s_wr_then_rd |=> (cal.rd_q == $past(cal.wr_data, 2));
  endproperty
  a_cal_readback: assert property (p_cal_readback) else $error("Calibration word read back wrong.");

  property p_ofs_apply;
    @(posedge clock) disable iff (!arst_n)
    (cal.wr_en && !cal.wr_idx[2] && (cal.wr_idx[1:0] == cal.ch_sel)) ##1 (!cal.wr_en && $stable(cal.ch_sel))
    |=> (cal.ch_offset == $past(cal.wr_data, 2));
  endproperty
  a_ofs_apply: assert property (p_ofs_apply) else $error("Offset not applied to channel.");

  property p_gain_apply;
    @(posedge clock) disable iff (!arst_n)
    (cal.wr_en && cal.wr_idx[2] && (cal.wr_idx[1:0] == cal.ch_sel)) ##1 (!cal.wr_en && $stable(cal.ch_sel))
    |=> (cal.ch_gain == $past(cal.wr_data, 2));
  endproperty
  a_gain_apply: assert property (p_gain_apply) else $error("Gain not applied to channel.");

endmodule

// ---- testbench/apcrb_host_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Host controller model
// ----------------------------------------------------------------------------
module apcrb_host_model (
  input  wire logic        clock,      // System clock.
  output logic      [7:0]  reg_addr,   // Register address.
  output logic      [23:0] reg_wdata,  // Register write data.
  output logic             reg_wr,     // Write strobe.
  output logic             reg_rd,     // Read strobe.
  input  wire logic [23:0] reg_rdata,  // Read data.
  output logic             sync_n_pin  // Shared alignment line, active low.
);
  initial
  begin
    reg_addr   = 8'h00;
    reg_wdata  = 24'h000000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    sync_n_pin = 1'b1;
  end

  // Released bus lines show the inverse of the last value so stale data never matches.
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // A write followed by a read with no gap, as the bus allows.
  task automatic wr_rd(input logic [7:0] a, input logic [23:0] w, output logic [23:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    reg_wdata <= ~w;
    @(posedge clock);
    reg_rd    <= 1'b0;
    reg_addr  <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // Low holds every device on the line that has alignment enabled; the release starts them together.
  task automatic align(input logic level);
    @(posedge clock);
    sync_n_pin <= level;
  endtask

  // The lowest digit is a silicon revision, so only the upper digits identify the part.
  function automatic logic part_ok(input logic [15:0] id, input logic [11:0] code);
    return id[15:4] === code;
  endfunction
endmodule

// ---- testbench/adc_pin_cal_register_bank_test.sv ----
`timescale 1ns/1ps

module adc_pin_cal_register_bank_test
  import apcrb_pkg::*;
;
  localparam logic [11:0] PART  = 12'h3c7;  // Arbitrary value.
  localparam logic [3:0]  REV   = 4'h2;     // Arbitrary value.
  localparam apcrb_word_t TRIM0 = 24'h512340;
  localparam apcrb_word_t TRIM1 = 24'h5abcd0;
  localparam apcrb_word_t TRIM2 = 24'h5f00e0;
  localparam apcrb_word_t TRIM3 = 24'h501230;

  logic        clock;
  logic        arst_n;
  logic [7:0]  reg_addr;
  logic [23:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [23:0] reg_rdata;
  logic        sync_n_pin;
  logic        fault_ext_n;
  logic        fault_pin_i;
  logic        fault_pin_o;
  logic        fault_pin_oe;
  logic        adc_err_int;
  logic [1:0]  conv_chan;
  apcrb_word_t conv_offset;
  apcrb_word_t conv_gain;
  logic        conv_hold;
  logic        conv_start;
  logic        adc_fault;
  logic        irq;
  logic [23:0] d;
  logic [23:0] shadow [16];
  int          seed;
  int          mismatches;
  int          checked;

  // Open-drain pad: the device pulls low while enabled, otherwise the pull-up or the outside drives it.
  assign fault_pin_i = fault_pin_oe ? fault_pin_o : fault_ext_n;

  always #10 clock = ~clock;

  apcrb_host_model u_host (
    .clock      (clock),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .sync_n_pin (sync_n_pin)
  );

  apcrb_top #(
    .PART_CODE   (PART),
    .SILICON_REV (REV),
    .GAIN_TRIM0  (TRIM0),
    .GAIN_TRIM1  (TRIM1),
    .GAIN_TRIM2  (TRIM2),
    .GAIN_TRIM3  (TRIM3)
  ) uut (
    .clock        (clock),
    .arst_n       (arst_n),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .sync_n_pin   (sync_n_pin),
    .fault_pin_i  (fault_pin_i),
    .fault_pin_o  (fault_pin_o),
    .fault_pin_oe (fault_pin_oe),
    .adc_err_int  (adc_err_int),
    .conv_chan    (conv_chan),
    .conv_offset  (conv_offset),
    .conv_gain    (conv_gain),
    .conv_hold    (conv_hold),
    .conv_start   (conv_start),
    .adc_fault    (adc_fault),
    .irq          (irq)
  );

  // --------------------------------------------------------------------------
  // Expectations and checks
  // --------------------------------------------------------------------------
  function automatic logic [23:0] exp_rst(input int a);
    case (a)
      6:       return 24'h000800;
      7:       return {8'h00, PART, REV};
      8, 9, 10, 11: return 24'h800000;
      12:      return TRIM0;
      13:      return TRIM1;
      14:      return TRIM2;
      15:      return TRIM3;
      default: return 24'h000000;
    endcase
  endfunction

  task automatic chk_word(input string n, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_word(n, {23'h000000, e}, {23'h000000, g});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic done(input string n);
    $display("test %s finished, %0d mismatches so far", n, mismatches);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    summarize();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    arst_n = 1'b0;
    fault_ext_n = 1'b1;
    adc_err_int = 1'b0;
    conv_chan = 2'd0;
    seed = 91;
    mismatches = 0;
    checked = 0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    for (int a = 6; a < 16; a++)
    begin
      u_host.rd(8'(a), d);
      shadow[a] = exp_rst(a);
      chk_word("reset value", shadow[a], d);
    end
    u_host.rd(8'h07, d);
    chk_bit("part code", 1'b1, u_host.part_ok(d[15:0], PART));
    done("reset values");
    for (int a = 8; a < 16; a++)
    begin
      shadow[a] = 24'($random(seed));
      u_host.wr(8'(a), shadow[a]);
    end
    u_host.wr(8'h07, 24'($random(seed)));
    u_host.wr(8'h06, 24'hffffff);
    shadow[6] = 24'h000e00;
    for (int a = 6; a < 16; a++)
    begin
      u_host.rd(8'(a), d);
      chk_word("register readback", shadow[a], d);
    end
    shadow[11] = 24'($random(seed));
    u_host.wr_rd(8'h0b, shadow[11], d);
    chk_word("write then read", shadow[11], d);
    u_host.wr_rd(8'h07, 24'($random(seed)), d);
    chk_word("identity after write", shadow[7], d);
    u_host.rd(8'h20, d);
    chk_word("unmapped read", 24'h000000, d);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clock);
      conv_chan <= 2'(c);
      cyc(2);
      chk_word("conv_offset", shadow[8 + c], conv_offset);
      chk_word("conv_gain", shadow[12 + c], conv_gain);
    end
    done("calibration");
    u_host.wr(8'h10, 24'h000003);
    u_host.wr(8'h06, 24'h000800);
    u_host.align(1'b0);
    cyc(3);
    chk_bit("conv_hold", 1'b1, conv_hold);
    u_host.align(1'b1);
    cyc(3);
    chk_bit("conv_hold", 1'b0, conv_hold);
    chk_bit("conv_start", 1'b1, conv_start);
    cyc(1);
    chk_bit("conv_start", 1'b0, conv_start);
    chk_bit("irq", 1'b0, irq);
    u_host.wr(8'h11, 24'h000002);
    cyc(1);
    chk_bit("irq", 1'b1, irq);
    u_host.wr(8'h10, 24'h000002);
    cyc(1);
    chk_bit("irq", 1'b0, irq);
    u_host.wr(8'h06, 24'h000000);
    u_host.align(1'b0);
    cyc(5);
    chk_bit("conv_hold", 1'b0, conv_hold);
    u_host.align(1'b1);
    done("alignment");
    u_host.wr(8'h06, 24'h000200);
    fault_ext_n <= 1'b0;
    cyc(4);
    chk_bit("adc_fault", 1'b1, adc_fault);
    u_host.rd(8'h12, d);
    chk_bit("status fault", 1'b1, d[0]);
    fault_ext_n <= 1'b1;
    cyc(4);
    chk_bit("adc_fault", 1'b0, adc_fault);
    u_host.wr(8'h06, 24'h000000);
    fault_ext_n <= 1'b0;
    cyc(4);
    chk_bit("adc_fault", 1'b0, adc_fault);
    chk_bit("fault_pin_oe", 1'b0, fault_pin_oe);
    fault_ext_n <= 1'b1;
    u_host.wr(8'h10, 24'h000003);
    u_host.wr(8'h11, 24'h000001);
    u_host.wr(8'h06, 24'h000400);
    adc_err_int <= 1'b1;
    cyc(2);
    chk_bit("fault_pin_oe", 1'b1, fault_pin_oe);
    chk_bit("fault pad", 1'b0, fault_pin_i);
    chk_bit("irq", 1'b1, irq);
    adc_err_int <= 1'b0;
    u_host.wr(8'h10, 24'h000001);
    cyc(2);
    chk_bit("irq", 1'b0, irq);
    chk_bit("fault_pin_oe", 1'b0, fault_pin_oe);
    u_host.wr(8'h06, 24'h000600);
    adc_err_int <= 1'b1;
    cyc(2);
    chk_bit("fault_pin_oe", 1'b0, fault_pin_oe);
    adc_err_int <= 1'b0;
    done("fault pin");
    @(posedge clock);
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    u_host.rd(8'h06, d);
    chk_word("pin config after reset", 24'h000800, d);
    u_host.rd(8'h0c, d);
    chk_word("gain after reset", TRIM0, d);
    done("second reset");
    summarize();
  end
endmodule
